// *** design/qr_timing_consts.vh ***
// Constants of the quasi-resonant flyback switching-cycle sequencer.
// Assumes the sequencer runs from a 100 MHz clock; levels are 12-bit codes of 1 mV each.
`ifndef QR_TIMING_CONSTS_VH
`define QR_TIMING_CONSTS_VH

`define CLK_MHZ 100
// Times in their own units and cycle counts derived from them.
`define BLANKING_NS 275
`define BLANKING_CYC ((`BLANKING_NS * `CLK_MHZ + 999) / 1000)
`define SHORT_TOUT_US 6
`define SHORT_TOUT_CYC (`SHORT_TOUT_US * `CLK_MHZ)
`define LONG_TOUT_US 100
`define LONG_TOUT_CYC (`LONG_TOUT_US * `CLK_MHZ)
`define SOFT_START_MS 4
`define SOFT_START_CYC (`SOFT_START_MS * 1000 * `CLK_MHZ)
`define MAX_FREQ_KHZ 140
`define MAX_FREQ_CYC ((`CLK_MHZ * 1000 + `MAX_FREQ_KHZ - 1) / `MAX_FREQ_KHZ)
`define JITTER_HZ 250
`define JITTER_PERIOD_CYC (`CLK_MHZ * 1000000 / `JITTER_HZ)
// Levels in mV.
`define CLAMP_FULL_MV 12'h320
`define CURRENT_LIMIT_MV 12'h320
`define MIN_PEAK_MV 12'h0c8
`define JITTER_PEAK_MV 12'h032
`define HYSTERESIS_MV 12'h258
`define FOLDBACK_MV 12'h320
`define FB_DIVIDER_SHIFT 2
// Falling thresholds for leaving valley n toward n+1.
`define VALLEY_FALL_1 12'h578
`define VALLEY_FALL_2 12'h4b0
`define VALLEY_FALL_3 12'h44c
`define VALLEY_FALL_4 12'h3e8
`define VALLEY_FALL_5 12'h384
`define VALLEY_MAX 3'h6

`endif

// *** design/valley_select.v ***
// Hysteretic valley selection from the feedback level.
// Assumes feedback_level is a code on the sequencer clock; updates once per switching cycle.
`timescale 1ns/1ps
`include "qr_timing_consts.vh"
`default_nettype none

module valley_select (
  // Clock and reset
  input wire mclk,
  input wire srst,
  input wire clk_en,
  // Control
  input wire update,
  input wire [11:0] feedback_level,
  // Result
  output reg [2:0] valley_sel_q,
  output reg foldback_q
);

  reg [11:0] fall_thr;
  reg [2:0] sel_d;

  always @* begin
    case (valley_sel_q)
      3'h1: fall_thr = `VALLEY_FALL_1;
      3'h2: fall_thr = `VALLEY_FALL_2;
      3'h3: fall_thr = `VALLEY_FALL_3;
      3'h4: fall_thr = `VALLEY_FALL_4;
      3'h5: fall_thr = `VALLEY_FALL_5;
      default: fall_thr = `FOLDBACK_MV;
    endcase
  end

  // The rising threshold for leaving valley n toward n-1 is the falling threshold of valley n-1 plus hysteresis.
  always @* begin
    sel_d = valley_sel_q;
    if (feedback_level < fall_thr && valley_sel_q < `VALLEY_MAX) begin
      sel_d = valley_sel_q + 3'h1;
    end else if (valley_sel_q > 3'h1 && valley_sel_q <= `VALLEY_MAX) begin
      case (valley_sel_q)
        3'h2: if (feedback_level > `VALLEY_FALL_1 + `HYSTERESIS_MV) sel_d = 3'h1;
        3'h3: if (feedback_level > `VALLEY_FALL_2 + `HYSTERESIS_MV) sel_d = 3'h2;
        3'h4: if (feedback_level > `VALLEY_FALL_3 + `HYSTERESIS_MV) sel_d = 3'h3;
        3'h5: if (feedback_level > `VALLEY_FALL_4 + `HYSTERESIS_MV) sel_d = 3'h4;
        3'h6: if (feedback_level > `VALLEY_FALL_5 + `HYSTERESIS_MV) sel_d = 3'h5;
        default: sel_d = valley_sel_q;
      endcase
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      valley_sel_q <= 3'h1;
      foldback_q <= 1'b0;
    end else if (clk_en && update) begin
      valley_sel_q <= sel_d;
      foldback_q <= (valley_sel_q == `VALLEY_MAX) && (feedback_level < `FOLDBACK_MV);
    end
  end

endmodule // valley_select

`default_nettype wire

// *** design/qr_flyback_switch_timing.v ***
// Switching-cycle sequencer of a quasi-resonant peak-current-mode flyback controller.
// Assumes sense levels come in as 12-bit mV codes from converters on another clock, so every analog
// input is resynchronised; the valley comparator output is an asynchronous pin.
`timescale 1ns/1ps
`include "qr_timing_consts.vh"
`default_nettype none

// Contract
// - Drive off when current exceeds feedback/4.
// - Soft-start clamp ramps 0 to 0.8 V.
// - Absolute current limit stops drive, flags overload.
// - Blank current compare after each turn-on.
// - Setpoint never below minimum floor.
// - Long valley timeout during soft-start.
// - Add 0-50 mV 250 Hz triangle jitter.
// - Jitter polarity alternates each switching cycle.
// - Valleys start on-phase, current ends it.
// - Valley registered on zero-crossing falling edge.
// - Valley counter switches at selected valley 1-6.
// - Valley selection held within hysteresis band.
// - Falling and rising valley thresholds as listed.
// - Timeout expiry counts as a valley.
// - Restart timeout repeatedly until count reached.
// - Optional 140 kHz maximum frequency clamp.
// - Soft-start reference starts at zero.
// - Below 0.8 V at sixth valley, foldback.
module qr_flyback_switch_timing #(
  parameter MAX_FREQ_CLAMP = 0,
  parameter BLANK_CYC = `BLANKING_CYC,
  parameter SHORT_TOUT = `SHORT_TOUT_CYC,
  parameter LONG_TOUT = `LONG_TOUT_CYC,
  parameter SOFT_START = `SOFT_START_CYC,
  parameter JITTER_PERIOD = `JITTER_PERIOD_CYC,
  parameter MAX_FREQ_PERIOD = `MAX_FREQ_CYC
) (
  // Clock, reset, enable
  input wire mclk,
  input wire srst,
  input wire clk_en,
  // Analog front end
  input wire [11:0] current_sense,
  input wire [11:0] feedback_level,
  input wire zero_crossing_input,
  // Gate drive and status
  output reg gate_drive,
  output reg overload_timer_en,
  output reg soft_start_active,
  output reg foldback_request,
  output reg [2:0] valley_selected
);

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  // Each bit is resynchronised on its own, so a code that changes in several bits at once
  // may be seen half-updated for one cycle; the converters are expected to step slowly.
  reg [11:0] cs_meta_q;
  reg [11:0] cs_q;
  reg [11:0] fb_meta_q;
  reg [11:0] fb_q;
  reg zc_meta_q;
  reg zc_q;
  reg zc_prev_q;

  always @(posedge mclk) begin
    if (srst) begin
      cs_meta_q <= 12'h000;
      cs_q <= 12'h000;
      fb_meta_q <= 12'h000;
      fb_q <= 12'h000;
      zc_meta_q <= 1'b0;
      zc_q <= 1'b0;
      zc_prev_q <= 1'b0;
    end else if (clk_en) begin
      cs_meta_q <= current_sense;
      cs_q <= cs_meta_q;
      fb_meta_q <= feedback_level;
      fb_q <= fb_meta_q;
      zc_meta_q <= zero_crossing_input;
      zc_q <= zc_meta_q;
      zc_prev_q <= zc_q;
    end
  end

  // High means the winding sits above the trigger level; a fall marks a valley.
  // The stages reset to the low idle level, so leaving reset cannot fake a valley.
  wire valley_edge = zc_prev_q & ~zc_q;

  // ---------------------------------------------------------------------------
  // Soft-start reference
  // ---------------------------------------------------------------------------
  reg [31:0] ss_cnt_q;
  reg [11:0] ss_ref;

  always @(posedge mclk) begin
    if (srst) begin
      ss_cnt_q <= 32'h0;
    end else if (clk_en && ss_cnt_q < SOFT_START) begin
      ss_cnt_q <= ss_cnt_q + 32'h1;
    end
  end

  wire ss_active = (ss_cnt_q < SOFT_START);
  wire [43:0] ss_prod = ss_cnt_q * {20'h0, `CLAMP_FULL_MV};
  // The quotient never exceeds the full clamp level, so its low twelve bits hold all of it.
  wire [43:0] ss_quot = ss_prod / SOFT_START;

  always @* begin
    ss_ref = `CLAMP_FULL_MV;
    if (ss_active) begin
      ss_ref = ss_quot[11:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Jitter triangle
  // ---------------------------------------------------------------------------
  localparam HALF_JIT = JITTER_PERIOD / 2;
  reg [31:0] jit_cnt_q;
  reg jit_up_q;
  reg [11:0] jitter;

  always @(posedge mclk) begin
    if (srst) begin
      jit_cnt_q <= 32'h0;
      jit_up_q <= 1'b1;
    end else if (clk_en) begin
      if (jit_cnt_q >= HALF_JIT - 1) begin
        jit_cnt_q <= 32'h0;
        jit_up_q <= ~jit_up_q;
      end else begin
        jit_cnt_q <= jit_cnt_q + 32'h1;
      end
    end
  end

  wire [43:0] jit_prod = jit_cnt_q * {20'h0, `JITTER_PEAK_MV};
  wire [43:0] jit_frac = jit_prod / HALF_JIT;

  always @* begin
    if (jit_up_q) begin
      jitter = jit_frac[11:0];
    end else begin
      jitter = `JITTER_PEAK_MV - jit_frac[11:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Peak-current setpoint and comparators
  // ---------------------------------------------------------------------------
  reg jit_neg_q;
  reg [11:0] setpoint;
  reg [12:0] cs_jit;

  always @* begin
    setpoint = fb_q >> `FB_DIVIDER_SHIFT;
    if (setpoint > ss_ref) begin
      setpoint = ss_ref;
    end
    if (setpoint < `MIN_PEAK_MV) begin
      setpoint = `MIN_PEAK_MV;
    end
  end

  // The subtraction floors at zero so a negative jitter never wraps the sensed value.
  always @* begin
    if (!jit_neg_q) begin
      cs_jit = {1'b0, cs_q} + {1'b0, jitter};
    end else if (cs_q > jitter) begin
      cs_jit = {1'b0, cs_q - jitter};
    end else begin
      cs_jit = 13'h0;
    end
  end

  // The floor is applied after the soft-start clamp, so early pulses still reach the floor.
  wire pwm_trip = cs_jit > {1'b0, setpoint};
  wire limit_trip = cs_q >= `CURRENT_LIMIT_MV;

  // ---------------------------------------------------------------------------
  // Cycle sequencer
  // ---------------------------------------------------------------------------
  localparam ST_ON = 3'b001;
  localparam ST_OFF = 3'b010;
  localparam ST_WAIT = 3'b100;

  reg [2:0] state_q;
  reg [15:0] blank_q;
  reg [31:0] tout_q;
  reg [31:0] period_q;
  reg [2:0] valley_cnt_q;
  wire [2:0] valley_sel;
  wire foldback;
  wire cycle_start;

  wire [31:0] tout_lim = ss_active ? LONG_TOUT : SHORT_TOUT;
  wire tout_exp = (tout_q >= tout_lim - 1);
  wire valley_ev = valley_edge | tout_exp;
  wire freq_ok = (MAX_FREQ_CLAMP == 0) || (period_q >= MAX_FREQ_PERIOD - 1);
  wire blanked = (blank_q != 16'h0);
  wire count_hit = valley_ev && (valley_cnt_q + 3'h1 >= valley_sel);

  assign cycle_start = (state_q == ST_WAIT) && freq_ok;

  always @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_OFF;
      blank_q <= 16'h0;
      tout_q <= 32'h0;
      period_q <= 32'h0;
      valley_cnt_q <= 3'h0;
      jit_neg_q <= 1'b0;
      gate_drive <= 1'b0;
      overload_timer_en <= 1'b0;
    end else if (clk_en) begin
      if (period_q != 32'hffffffff) begin
        period_q <= period_q + 32'h1;
      end
      case (state_q)
        ST_ON: begin
          overload_timer_en <= 1'b0;
          if (blanked) begin
            blank_q <= blank_q - 16'h1;
          end else if (limit_trip || pwm_trip) begin
            gate_drive <= 1'b0;
            overload_timer_en <= limit_trip;
            valley_cnt_q <= 3'h0;
            tout_q <= 32'h0;
            state_q <= ST_OFF;
          end
        end
        ST_OFF: begin
          overload_timer_en <= 1'b0;
          tout_q <= valley_ev ? 32'h0 : tout_q + 32'h1;
          if (count_hit) begin
            state_q <= ST_WAIT;
          end else if (valley_ev) begin
            valley_cnt_q <= valley_cnt_q + 3'h1;
          end
        end
        ST_WAIT: begin
          if (freq_ok) begin
            gate_drive <= 1'b1;
            blank_q <= BLANK_CYC[15:0];
            period_q <= 32'h0;
            jit_neg_q <= ~jit_neg_q;
            state_q <= ST_ON;
          end
        end
        default: begin
          gate_drive <= 1'b0;
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Valley selection and status
  // ---------------------------------------------------------------------------
  valley_select u_valley_select (
    .mclk(mclk),
    .srst(srst),
    .clk_en(clk_en),
    .update(cycle_start),
    .feedback_level(fb_q),
    .valley_sel_q(valley_sel),
    .foldback_q(foldback)
  );

  always @(posedge mclk) begin
    if (srst) begin
      soft_start_active <= 1'b1;
      foldback_request <= 1'b0;
      valley_selected <= 3'h1;
    end else if (clk_en) begin
      soft_start_active <= ss_active;
      foldback_request <= foldback;
      valley_selected <= valley_sel;
    end
  end

endmodule // qr_flyback_switch_timing

`default_nettype wire

// *** tb/qr_timing_checker.sv ***
// Assertions on the ports of the switch-timing sequencer.
// Assumes the bind below, one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module qr_timing_checker #(
  parameter BLANK_CYC = 28,
  parameter SOFT_START = 2000
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [11:0] current_sense,
  input wire logic [11:0] feedback_level,
  input wire logic zero_crossing_input,
  input wire logic gate_drive,
  input wire logic overload_timer_en,
  input wire logic soft_start_active,
  input wire logic foldback_request,
  input wire logic [2:0] valley_selected
);
  int on_q = 0;
  int run_q = 0;
  always @(posedge mclk) begin
    on_q <= (srst || !gate_drive) ? 0 : on_q + 1;
    run_q <= srst ? 0 : run_q + 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_limit_drop: assert property (overload_timer_en |-> $fell(gate_drive))
    else $error("limit flag without drive drop");
  a_limit_cause: assert property (overload_timer_en |-> $past(current_sense, 3) >= 12'h320)
    else $error("limit flag below limit");
  a_blank_min: assert property ($fell(gate_drive) |-> on_q >= BLANK_CYC)
    else $error("pulse ended inside blanking");
  a_soft_len: assert property ($fell(soft_start_active) |-> run_q >= SOFT_START - 1)
    else $error("soft-start ended early");
  a_soft_once: assert property (!$rose(soft_start_active))
    else $error("soft-start restarted");
  a_valley_range: assert property (valley_selected >= 3'h1 && valley_selected <= 3'h6)
    else $error("valley out of range");
  a_fold_sixth: assert property (foldback_request |-> valley_selected == 3'h6)
    else $error("foldback off sixth valley");
  a_reset_state: assert property ($fell(srst) |-> !gate_drive && soft_start_active
    && valley_selected == 3'h1)
    else $error("bad state after reset");
  a_off_gap: assert property ($rose(gate_drive) |-> $past(gate_drive, 2) == 1'b0)
    else $error("off phase too short");
  cover property ($rose(overload_timer_en));
  cover property ($fell(soft_start_active));
  cover property ($rose(foldback_request));
  cover property (valley_selected == 3'h5 && $rose(gate_drive));
endmodule // qr_timing_checker
bind qr_flyback_switch_timing qr_timing_checker #(.BLANK_CYC(BLANK_CYC),
  .SOFT_START(SOFT_START)) chk (.mclk, .srst, .clk_en, .current_sense, .feedback_level,
  .zero_crossing_input, .gate_drive, .overload_timer_en, .soft_start_active,
  .foldback_request, .valley_selected);
`default_nettype wire

// *** tb/flyback_stage_model.sv ***
// Behavioural flyback stage: switch current ramp and winding comparator.
// Assumes the gate drive changes on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module flyback_stage_model (
  // Clock and gate
  input wire logic mclk,
  input wire logic gate_drive,
  // Stage shape
  input wire logic [11:0] slope,
  input wire logic ringing,
  // Sensed signals
  output var logic [11:0] current_sense,
  output var logic zero_crossing_input
);
  int t_q = 0;
  wire [12:0] sum = {1'b0, current_sense} + {1'b0, slope};
  initial begin
    current_sense = 12'h000;
    zero_crossing_input = 1'b0;
  end
  always @(posedge mclk) begin
    if (gate_drive) begin
      t_q <= 0;
      current_sense <= sum[12] ? 12'hfff : sum[11:0];
      zero_crossing_input <= 1'b0;
    end else begin
      t_q <= t_q + 1;
      current_sense <= 12'h000;
      // A damped winding never crosses, so only timeouts can count valleys.
      zero_crossing_input <= ringing && (t_q < 40 || t_q % 20 >= 10);
    end
  end
endmodule // flyback_stage_model
`default_nettype wire

// *** tb/tb_qr_flyback_switch_timing.sv ***
// Self-checking bench of the switch-timing sequencer against a stage model.
// Assumes shortened soft-start, long timeout and jitter period.
`timescale 1ns/1ps
`default_nettype none
module tb_qr_flyback_switch_timing;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic [11:0] feedback_level = 12'hbb8;
  logic [11:0] slope = 12'hfff;
  logic ringing = 1'b0;
  wire [11:0] current_sense;
  wire zero_crossing_input, gate_drive, overload_timer_en;
  wire soft_start_active, foldback_request;
  wire [2:0] valley_selected;
  int mismatches = 0;
  int checks_done = 0;
  int wait_len, on_len, off_len;
  logic ovl_seen;
  wire [11:0] cs_clamped;
  wire zc_clamped, drive_clamped;
  logic drive_prev_q = 1'b0;
  int gap_q = 0;
  int min_gap_q = 0;
  always #5 mclk = ~mclk;
  qr_flyback_switch_timing #(.SOFT_START(2000), .LONG_TOUT(200), .JITTER_PERIOD(400)) dut (
    .mclk, .srst, .clk_en, .current_sense, .feedback_level, .zero_crossing_input,
    .gate_drive, .overload_timer_en, .soft_start_active, .foldback_request, .valley_selected);
  flyback_stage_model stage (.mclk, .gate_drive, .slope, .ringing, .current_sense,
    .zero_crossing_input);
  // A second sequencer with the frequency clamp built in, fed the same stimulus.
  qr_flyback_switch_timing #(.MAX_FREQ_CLAMP(1), .SOFT_START(2000), .LONG_TOUT(200),
    .JITTER_PERIOD(400)) dut_clamp (
    .mclk, .srst, .clk_en, .current_sense(cs_clamped), .feedback_level,
    .zero_crossing_input(zc_clamped), .gate_drive(drive_clamped), .overload_timer_en(),
    .soft_start_active(), .foldback_request(), .valley_selected());
  flyback_stage_model stage_clamp (.mclk, .gate_drive(drive_clamped), .slope, .ringing,
    .current_sense(cs_clamped), .zero_crossing_input(zc_clamped));
  // Shortest spacing between turn-ons of the clamped sequencer, in clock cycles.
  always @(posedge mclk) begin
    drive_prev_q <= drive_clamped;
    if (drive_clamped && !drive_prev_q) begin
      gap_q <= 1;
      if (gap_q > 0 && (min_gap_q == 0 || gap_q < min_gap_q)) begin
        min_gap_q <= gap_q;
      end
    end else if (gap_q > 0) begin
      gap_q <= gap_q + 1;
    end
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task wrap_up();
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Measures wait to turn-on, on time and the following off time in clock samples.
  task pulse();
    wait_len = 0;
    on_len = 0;
    off_len = 0;
    ovl_seen = 1'b0;
    while (gate_drive !== 1'b1 && wait_len < 9000) begin
      @(posedge mclk);
      wait_len++;
    end
    while (gate_drive === 1'b1 && on_len < 9000) begin
      @(posedge mclk);
      on_len++;
      ovl_seen |= overload_timer_en;
    end
    while (gate_drive !== 1'b1 && off_len < 9000) begin
      @(posedge mclk);
      off_len++;
    end
    check("pulse in time", wait_len < 9000 && on_len < 9000 && off_len < 9000, 1);
  endtask
  task t_start();
    check("valley after reset", valley_selected, 1);
    check("soft-start after reset", soft_start_active, 1);
    pulse();
    check("first start", wait_len inside {[200:206]}, 1);
    check("blanked on time", on_len inside {[28:34]}, 1);
    check("limit flag", ovl_seen, 1);
    check("soft off time", off_len inside {[199:206]}, 1);
  endtask
  task t_peak();
    repeat (1900) @(posedge mclk);
    check("soft-start done", soft_start_active, 0);
    slope <= 12'h004;
    feedback_level <= 12'h7d0;
    // The first call may start mid-pulse, so only the second is judged.
    repeat (2) pulse();
    check("peak on time", on_len inside {[110:142]}, 1);
    check("short timeout", off_len inside {[598:606]}, 1);
  endtask
  task t_floor();
    feedback_level <= 12'h190;
    repeat (7) pulse();
    check("floor on time", on_len inside {[36:68]}, 1);
    check("sixth valley", valley_selected, 6);
    check("foldback", foldback_request, 1);
  endtask
  task t_hold();
    feedback_level <= 12'h5aa;
    repeat (2) pulse();
    check("held at sixth", valley_selected, 6);
    check("foldback left", foldback_request, 0);
    feedback_level <= 12'h60e;
    repeat (3) pulse();
    check("fifth valley", valley_selected, 5);
    check("five timeouts", off_len inside {[2995:3010]}, 1);
  endtask
  task t_ring();
    ringing <= 1'b1;
    repeat (2) pulse();
    check("fifth ring valley", off_len inside {[118:135]}, 1);
    feedback_level <= 12'hbb8;
    repeat (6) pulse();
    check("first valley", valley_selected, 1);
    check("first ring valley", off_len inside {[40:52]}, 1);
  endtask
  // A low enable must freeze the sequencer mid-pulse, blanking timer included.
  task t_freeze();
    clk_en <= 1'b0;
    repeat (300) @(posedge mclk);
    check("frozen drive", gate_drive, 1);
    clk_en <= 1'b1;
    pulse();
    check("blanking after freeze", on_len inside {[27:30]}, 1);
    check("limit after freeze", ovl_seen, 1);
    check("clamp spacing", min_gap_q, 715);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_start();
    t_peak();
    t_floor();
    t_hold();
    t_ring();
    t_freeze();
    wrap_up();
  end
  initial begin
    #1000000;
    mismatches++;
    wrap_up();
  end
endmodule // tb_qr_flyback_switch_timing
`default_nettype wire
